// *** core/stop_gating.sv ***
`include "stop_gating_params.svh"
module stop_gating
(
   // Clock and reset
   input  wire logic                        clk_i,
   input  wire logic                        resetn_i,
   // CPU side
   input  wire logic                        stop_req_i,
   input  wire stop_gating_pkg::stop_cfg_s  cfg_i,
   input  wire logic                        powerdown_acknowledge_i,
   // Wake sources, from pins
   input  wire logic                        reset_pin_i,
   input  wire logic                        async_irq_pin_i,
   // Wake sources, same clock domain
   input  wire logic                        periph_wake_i,
   input  wire logic                        deep_wake_i,
   // Module side
   output logic                             periph_clk_en_o,
   output logic                             debug_clk_en_o,
   output stop_gating_pkg::power_en_s       power_en_o,
   output stop_gating_pkg::power_en_s       standby_o,
   output logic                             pin_hold_o,
   output logic                             powerdown_wake_flag_o,
   output logic                             illegal_opcode_reset_o,
   output logic [1:0]                       stop_mode_o
);
   import stop_gating_pkg::*;

   // ************************************************
   // Pin synchronisers
   // ************************************************
   logic [1:0] rst_sync;
   logic [1:0] irq_sync;
   // Two stages; only the second stage is read
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         rst_sync <= 2'h0;
         irq_sync <= 2'h0;
      end
      else
      begin
         rst_sync <= {rst_sync[0], reset_pin_i};
         irq_sync <= {irq_sync[0], async_irq_pin_i};
      end
   end

   // ************************************************
   // Mode sequencer
   // ************************************************
   stop_state_e state;
   stop_state_e next_state;
   logic        wake_flag;
   logic        next_wake_flag;
   logic        hold;
   logic        next_hold;
   logic        next_ill_rst;
   logic        debug_forces;
   logic        lowvolt_forces;
   logic        force_shallow;
   logic        pin_wake;

   // ************************************************
   // Stop entry and wake decode
   // ************************************************
   // Debug keeps its clocks alive, so deep power-down is never allowed
   assign debug_forces   = cfg_i.debug_mode_enable;
   // The detector needs the regulator, which deep stop would switch off
   assign lowvolt_forces = cfg_i.lowvolt_detect_enable & cfg_i.lowvolt_stop_enable;
   assign force_shallow  = debug_forces | lowvolt_forces;
   // Only synchronised pin levels are read here, never the raw pins
   assign pin_wake       = rst_sync[1] | irq_sync[1];

   // Next state, wake flag and pin hold of the sequencer
   always_comb
   begin
      next_state     = state;
      next_wake_flag = wake_flag;
      next_hold      = hold;
      next_ill_rst   = 1'h0;
      // Acknowledge clears the flag and opens the pin latches; in deep stop the branch below keeps the latches closed and a deep wake sets the flag
      if (powerdown_acknowledge_i)
      begin
         next_wake_flag = 1'h0;
         next_hold      = 1'h0;
      end
      unique case (state)
         RUN:
         begin
            // A stop request is taken only while running
            if (stop_req_i)
            begin
               if (!cfg_i.stop_instruction_enable)
               begin
                  // Stop disabled: one-cycle request for an illegal-opcode reset
                  next_ill_rst = 1'h1;
               end
               else if (force_shallow || !cfg_i.partial_powerdown_select)
               begin
                  next_state = SHALLOW_STOP;
               end
               else
               begin
                  next_state = DEEP_STOP;
               end
            end
         end
         SHALLOW_STOP:
         begin
            // A pin or peripheral wake releases all gates next cycle; deep_wake_i is ignored
            if (pin_wake || periph_wake_i)
            begin
               next_state = RUN;
            end
         end
         DEEP_STOP:
         begin
            // Pins stay latched for the whole deep stop, even against an acknowledge
            next_hold = 1'h1;
            // Deep wake behaves like power-on: enables back to reset values
            if (rst_sync[1] || deep_wake_i)
            begin
               next_state     = RUN;
               next_wake_flag = 1'h1;
            end
         end
      endcase
   end

   // Sequencer state; the reset pulse output is registered straight from next_ill_rst
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         state     <= RUN;
         wake_flag <= `RST_WAKE_FLAG;
         hold      <= `RST_PIN_HOLD;
      end
      else
      begin
         state     <= next_state;
         wake_flag <= next_wake_flag;
         hold      <= next_hold;
      end
   end

   // ************************************************
   // Gate and power decode
   // ************************************************
   logic      next_periph_clk;
   logic      next_debug_clk;
   power_en_s next_power;
   power_en_s next_standby;
   logic      next_pin_hold;

   // Outputs follow the next mode, so they change on the edge that takes the request
   always_comb
   begin
      next_periph_clk = (next_state == RUN);
      next_debug_clk  = (next_state == RUN) | cfg_i.debug_mode_enable;
      next_power      = '1;
      next_standby    = '0;
      next_pin_hold   = next_hold | (next_state != RUN);
      unique case (next_state)
         RUN:
            next_power = '1;
         SHALLOW_STOP:
         begin
            next_power   = '0;
            next_standby = '1;
            next_standby.comparator_on = 1'h0;
            next_power.adc_on    = cfg_i.converter_async_clk_enable
                                 & cfg_i.lowvolt_detect_enable;
            next_power.clkgen_on = cfg_i.internal_refclk_enable
                                 & cfg_i.internal_ref_stop_enable;
            next_power.regulator_on = cfg_i.lowvolt_detect_enable
                                    | cfg_i.debug_mode_enable;
            next_power.oscillator_on = cfg_i.external_refclk_enable
                                     & cfg_i.external_ref_stop_enable
                                     & (~cfg_i.osc_high_range
                                        | cfg_i.lowvolt_detect_enable);
            next_power.rtc_on    = cfg_i.rtc_enable;
            // An optional module not kept on still keeps its state
            next_standby.adc_on        = ~next_power.adc_on;
            next_standby.clkgen_on     = ~next_power.clkgen_on;
            next_standby.regulator_on  = ~next_power.regulator_on;
            next_standby.oscillator_on = ~next_power.oscillator_on;
            next_standby.rtc_on        = ~cfg_i.rtc_enable;
         end
         DEEP_STOP:
         begin
            // Everything loses power but the counter when enabled; RAM keeps its state
            next_power          = '0;
            next_standby.ram_on = 1'h1;
            next_power.rtc_on   = cfg_i.rtc_enable;
            next_standby.rtc_on = ~cfg_i.rtc_enable;
         end
         default:
            next_power = '1;
      endcase
   end

   // All outputs registered
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         periph_clk_en_o        <= `RST_PERIPH_CLK_EN;
         debug_clk_en_o         <= `RST_DEBUG_CLK_EN;
         power_en_o             <= `RST_POWER_EN;
         standby_o              <= `RST_STANDBY;
         pin_hold_o             <= `RST_PIN_HOLD;
         powerdown_wake_flag_o  <= `RST_WAKE_FLAG;
         illegal_opcode_reset_o <= `RST_ILL_RESET;
         stop_mode_o            <= `RST_STOP_MODE;
      end
      else
      begin
         periph_clk_en_o        <= next_periph_clk;
         debug_clk_en_o         <= next_debug_clk;
         power_en_o             <= next_power;
         standby_o              <= next_standby;
         pin_hold_o             <= next_pin_hold;
         powerdown_wake_flag_o  <= next_wake_flag;
         illegal_opcode_reset_o <= next_ill_rst;
         stop_mode_o            <= next_state;
      end
   end
endmodule : stop_gating

// *** core/stop_gating_params.svh ***
`ifndef STOP_GATING_PARAMS_SVH
`define STOP_GATING_PARAMS_SVH
// Reset values of the registered outputs
`define RST_PERIPH_CLK_EN 1'h1
`define RST_DEBUG_CLK_EN  1'h1
`define RST_POWER_EN      13'h1FFF
`define RST_STANDBY       13'h0000
`define RST_WAKE_FLAG     1'h0
`define RST_PIN_HOLD      1'h0
`define RST_ILL_RESET     1'h0
`define RST_STOP_MODE     2'h0
`endif

// *** core/stop_gating_pkg.sv ***
`include "stop_gating_params.svh"
package stop_gating_pkg;
   // Stop state of the sequencer
   typedef enum logic [1:0] {RUN, SHALLOW_STOP, DEEP_STOP} stop_state_e;
   // Live configuration bits
   typedef struct packed {
      logic stop_instruction_enable;
      logic debug_mode_enable;
      logic lowvolt_detect_enable;
      logic lowvolt_stop_enable;
      logic partial_powerdown_select;
      logic converter_async_clk_enable;
      logic internal_refclk_enable;
      logic internal_ref_stop_enable;
      logic external_refclk_enable;
      logic external_ref_stop_enable;
      logic osc_high_range;
      logic rtc_enable;
   } stop_cfg_s;
   // Per-module power state: on = powered, standby = state kept
   typedef struct packed {
      logic cpu_on;
      logic ram_on;
      logic flash_on;
      logic port_on;
      logic comparator_on;
      logic adc_on;
      logic serial_on;
      logic timer_on;
      logic clkgen_on;
      logic can_on;
      logic rtc_on;
      logic regulator_on;
      logic oscillator_on;
   } power_en_s;
endpackage : stop_gating_pkg

// *** verification/stop_gating_props.sv ***
module stop_gating_props
(
   // Clock, reset and requests
   input  wire logic                       clk_i,
   input  wire logic                       resetn_i,
   input  wire logic                       stop_req_i,
   input  wire stop_gating_pkg::stop_cfg_s cfg_i,
   input  wire logic                       deep_wake_i,
   input  wire logic                       periph_wake_i,
   // Watched outputs
   input  wire logic                       periph_clk_en_o,
   input  wire logic                       debug_clk_en_o,
   input  wire stop_gating_pkg::power_en_s power_en_o,
   input  wire stop_gating_pkg::power_en_s standby_o,
   input  wire logic                       pin_hold_o,
   input  wire logic                       powerdown_wake_flag_o,
   input  wire logic                       illegal_opcode_reset_o,
   input  wire logic [1:0]                 stop_mode_o
);
   import stop_gating_pkg::*;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!resetn_i);
   // Stop request taken while running, and the one-cycle illegal reset pulse
   sequence s_req;
      stop_mode_o == 2'h0 && stop_req_i;
   endsequence
   sequence s_pulse;
      illegal_opcode_reset_o && stop_mode_o == 2'h0 ##1 !illegal_opcode_reset_o;
   endsequence
   property p_gate;
      stop_mode_o != 2'h0 |-> !periph_clk_en_o;
   endproperty
   a_gate: assert property (p_gate) else $error("clock runs in stop");
   property p_dbg;
      stop_mode_o != 2'h0 |-> debug_clk_en_o == $past(cfg_i.debug_mode_enable);
   endproperty
   a_dbg: assert property (p_dbg) else $error("debug clock wrong");
   property p_deep;
      stop_mode_o == 2'h2 |-> !power_en_o.cpu_on && !power_en_o.oscillator_on
         && !power_en_o.regulator_on && standby_o.ram_on && pin_hold_o;
   endproperty
   a_deep: assert property (p_deep) else $error("deep stop power wrong");
   property p_shal;
      stop_mode_o == 2'h1 |-> standby_o.cpu_on && standby_o.can_on
         && !power_en_o.comparator_on && !standby_o.comparator_on && pin_hold_o;
   endproperty
   a_shal: assert property (p_shal) else $error("shallow standby wrong");
   property p_adc;
      stop_mode_o == 2'h1 |-> power_en_o.adc_on ==
         ($past(cfg_i.converter_async_clk_enable) && $past(cfg_i.lowvolt_detect_enable));
   endproperty
   a_adc: assert property (p_adc) else $error("converter wrong");
   property p_crystal_oscillator;
      stop_mode_o == 2'h1 |-> power_en_o.oscillator_on ==
         ($past(cfg_i.external_refclk_enable) && $past(cfg_i.external_ref_stop_enable)
         && (!$past(cfg_i.osc_high_range) || $past(cfg_i.lowvolt_detect_enable)));
   endproperty
   a_crystal_oscillator: assert property (p_crystal_oscillator) else $error("oscillator wrong");
   property p_force;
      s_req and cfg_i.stop_instruction_enable && cfg_i.debug_mode_enable |=> stop_mode_o == 2'h1;
   endproperty
   a_force: assert property (p_force) else $error("debug did not force shallow");
   property p_ill;
      s_req and !cfg_i.stop_instruction_enable |=> s_pulse;
   endproperty
   a_ill: assert property (p_ill) else $error("illegal reset pulse wrong");
   property p_flag;
      stop_mode_o == 2'h2 && deep_wake_i |=>
         powerdown_wake_flag_o && pin_hold_o && stop_mode_o == 2'h0;
   endproperty
   a_flag: assert property (p_flag) else $error("deep wake wrong");
   property p_exit;
      stop_mode_o == 2'h1 && periph_wake_i |=> stop_mode_o == 2'h0 && periph_clk_en_o;
   endproperty
   a_exit: assert property (p_exit) else $error("shallow wake wrong");
endmodule : stop_gating_props
bind stop_gating stop_gating_props i_props (.*);

// *** verification/stop_gating_wake_src.sv ***
// Peripheral that raises its wake-up line one cycle after the bench asks
module stop_gating_wake_src
(
   // Clock and reset
   input  wire logic clk_i,
   input  wire logic resetn_i,
   // Command in, wake line out
   input  wire logic wake_cmd_i,
   output logic      periph_wake_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // Registered so the line never glitches at the sequencer's sampling edge
   always_ff @(posedge clk_i or negedge resetn_i)
      if (!resetn_i) periph_wake_o <= 1'b0;
      else periph_wake_o <= wake_cmd_i;
endmodule : stop_gating_wake_src

// *** verification/test_stop_gating.sv ***
module test_stop_gating;
   timeunit 1ns;
   timeprecision 1ps;
   import stop_gating_pkg::*;
   logic       clk_i = 0, resetn_i = 0, stop_req = 0, ack = 0, rst_pin = 0, irq_pin = 0;
   logic       wake_cmd = 0, deep_wake = 0, pw, clk_en, dbg_en, hold, flag, ill;
   logic [1:0] mode;
   stop_cfg_s  cfg = '0;
   power_en_s  pwr, sby;
   int         errors = 0, n_compared = 0, m, k;
   stop_gating i_dut (.clk_i(clk_i), .resetn_i(resetn_i), .stop_req_i(stop_req), .cfg_i(cfg),
      .powerdown_acknowledge_i(ack), .reset_pin_i(rst_pin), .async_irq_pin_i(irq_pin),
      .periph_wake_i(pw), .deep_wake_i(deep_wake), .periph_clk_en_o(clk_en),
      .debug_clk_en_o(dbg_en), .power_en_o(pwr), .standby_o(sby), .pin_hold_o(hold),
      .powerdown_wake_flag_o(flag), .illegal_opcode_reset_o(ill), .stop_mode_o(mode));
   stop_gating_wake_src i_src (.clk_i(clk_i), .resetn_i(resetn_i), .wake_cmd_i(wake_cmd),
      .periph_wake_o(pw));
   initial
   begin
      forever #12.5 clk_i = ~clk_i;
   end
   task end_sim;
      $display("errors %0d compared %0d", errors, n_compared);
      if (errors == 0 && n_compared > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : end_sim
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         errors++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : cmp
   task automatic pulse(ref logic s, input int n);
      s = 1;
      repeat (n) @(posedge clk_i) #1;
      s = 0;
   endtask : pulse
   // Reference model of every output but the illegal reset pulse, for mode m, flag f and pin hold h
   task automatic chk(input int m, input logic f, input logic h);
      power_en_s ep, es;
      ep = '1;
      es = '0;
      if (m != 0) ep = '0;
      ep.rtc_on = (m == 0) || cfg.rtc_enable;
      if (m == 2) es.ram_on = 1;
      if (m == 2) es.rtc_on = !cfg.rtc_enable;
      if (m == 1)
      begin
         ep.adc_on = cfg.converter_async_clk_enable && cfg.lowvolt_detect_enable;
         ep.clkgen_on = cfg.internal_refclk_enable && cfg.internal_ref_stop_enable;
         ep.regulator_on = cfg.lowvolt_detect_enable || cfg.debug_mode_enable;
         ep.oscillator_on = cfg.external_refclk_enable && cfg.external_ref_stop_enable
            && (!cfg.osc_high_range || cfg.lowvolt_detect_enable);
         es = ~ep;
         es.comparator_on = 0;
      end
      cmp(32'(mode), m);
      cmp(32'(pwr), 32'(ep));
      cmp(32'(sby), 32'(es));
      cmp(32'(clk_en), 32'(m == 0));
      cmp(32'(dbg_en), 32'(m == 0 || cfg.debug_mode_enable));
      cmp(32'({hold, flag}), 32'({h, f}));
   endtask : chk
   // Watchdog at 8000 cycles, far beyond the several hundred cycles the sequence needs
   initial
   begin
      #200us;
      errors++;
      end_sim();
   end
   initial
   begin
      m = $urandom(96);
      repeat (6) @(posedge clk_i);
      #1 resetn_i = 1;
      chk(0, 0, 0);
      for (int i = 0; i < 60; i++)
      begin
         repeat (3) @(posedge clk_i) #1; // Lets the pin synchronisers drain
         cfg = 12'($urandom);
         cfg.stop_instruction_enable = ($urandom % 4) != 0;
         // Low-voltage-in-stop is only set with the detector on, where all readings agree
         if (!cfg.lowvolt_detect_enable) cfg.lowvolt_stop_enable = 0;
         m = (cfg.debug_mode_enable || cfg.lowvolt_stop_enable) ? 1
           : 1 + cfg.partial_powerdown_select;
         pulse(stop_req, 1);
         if (!cfg.stop_instruction_enable)
         begin
            cmp(32'(ill), 1);
            chk(0, 0, 0);
            @(posedge clk_i) #1 cmp(32'(ill), 0);
            continue;
         end
         chk(m, 0, 1);
         @(posedge clk_i) #1; // Request line stays low for one edge between pulses
         pulse(stop_req, 1);
         chk(m, 0, 1);
         if (m == 2)
         begin
            pulse(wake_cmd, 1);
            @(posedge clk_i) #1 chk(2, 0, 1);
            pulse(deep_wake, 1);
            chk(0, 1, 1);
            pulse(ack, 1);
            chk(0, 0, 0);
         end
         else
         begin
            pulse(deep_wake, 1);
            chk(1, 0, 1);
            k = $urandom % 3;
            if (k == 0) pulse(wake_cmd, 2);
            else if (k == 1) pulse(rst_pin, 3);
            else pulse(irq_pin, 3);
            chk(0, 0, 0);
         end
      end
      // Reset in the middle of a deep stop, then a deep wake from the reset pin
      cfg = '0;
      cfg.stop_instruction_enable = 1;
      cfg.partial_powerdown_select = 1;
      cfg.rtc_enable = 1'($urandom);
      repeat (3) @(posedge clk_i) #1;
      pulse(stop_req, 1);
      chk(2, 0, 1);
      resetn_i = 0;
      @(posedge clk_i) #1 chk(0, 0, 0);
      @(posedge clk_i) #1 resetn_i = 1;
      chk(0, 0, 0);
      pulse(stop_req, 1);
      chk(2, 0, 1);
      pulse(rst_pin, 3);
      chk(0, 1, 1);
      pulse(ack, 1);
      chk(0, 0, 0);
      end_sim();
   end
endmodule : test_stop_gating
